//--- dfc_adjust.sv
// dynamic fan start temperature adjuster for one channel
`timescale 1ns/100ps
`default_nettype none
module dfc_adjust (
    input  wire logic       clk,         // system clock
    input  wire logic       rst_n,       // async reset, low
    input  wire logic       clk_en,      // freezes state when low
    input  wire logic       enable,      // dynamic adjust on
    input  wire logic       tick,        // monitoring cycle pulse
    input  wire logic [2:0] ivl_code,    // cycles between adjustments
    input  wire logic [7:0] cur_temp,    // current temperature
    input  wire logic [7:0] op_point,    // operating point
    input  wire logic [7:0] hi_limit,    // high limit
    input  wire logic [7:0] lo_limit,    // low limit
    input  wire logic [7:0] floor_prog,  // programmed fan start temp
    output logic      [7:0] floor_out    // fan start temp in use
);
    logic [7:0] floor_ff;
    logic [7:0] cnt_ff;
    logic [7:0] nxt_floor;
    logic [7:0] nxt_cnt;
    logic [7:0] ivl_len;
    logic       step_now;

    // interval length in monitoring cycles, doubling per code step
    assign ivl_len  = dfc_pkg::IVL_BASE << ivl_code;
    assign step_now = tick && (cnt_ff >= ivl_len - dfc_pkg::IVL_BASE);

    // floor tracks program when off, steps toward comfort when on
    always_comb begin
        nxt_floor = floor_ff;
        nxt_cnt   = cnt_ff;
        if (!enable) begin
            nxt_floor = floor_prog;
            nxt_cnt   = '0;
        end else if (tick) begin
            nxt_cnt = step_now ? 8'h00 : cnt_ff + dfc_pkg::IVL_BASE;
            if (step_now) begin
                if ((cur_temp > op_point || cur_temp > hi_limit)
                    && floor_ff > dfc_pkg::TEMP_MIN) begin
                    nxt_floor = floor_ff - dfc_pkg::FLOOR_STEP;
                end else if (cur_temp < lo_limit
                    && floor_ff < op_point
                    && floor_ff < dfc_pkg::TEMP_MAX) begin
                    nxt_floor = floor_ff + dfc_pkg::FLOOR_STEP;
                end
            end
        end
    end

    // register update
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            floor_ff <= 8'h00;
            cnt_ff   <= 8'h00;
        end else if (clk_en) begin
            floor_ff <= nxt_floor;
            cnt_ff   <= nxt_cnt;
        end
    end

    assign floor_out = floor_ff;

    a_floor_disabled: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !enable) |=> (floor_ff == $past(floor_prog)))
        else $error("floor not following program while disabled");
    a_floor_steady: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && enable && !step_now && $stable(enable))
        |=> (floor_ff == $past(floor_ff)))
        else $error("floor moved between adjustment points");
endmodule
`default_nettype wire

//--- dfc_ctrl.sv
// dynamic fan floor control register, capture and core undervolt policy
//
// Functional notes
// - bit 0 is top bit of remote 2 interval; low two bits elsewhere
// - interval code sets monitoring cycles between fan start adjustments
// - policy, standby, core low: flag, stop hot monitor, floors back to program, block shutdown
// - core undervolt drives alert only when its alert is enabled
// - bit 2 and overtemp line copy remote 1 temperature to operating point
// - bit 2 clear: remote 1 operating point keeps programmed value
// - bit 3 and overtemp line copy local temperature to operating point
// - bit 3 clear: local operating point keeps programmed value
// - bit 4 and overtemp line copy remote 2 temperature to operating point
// - bit 4 clear: remote 2 operating point keeps programmed value
// - bit 5 enables dynamic fan start adjustment on remote 1
// - bit 6 enables dynamic fan start adjustment on local channel
// - bit 7 enables dynamic fan start adjustment on remote 2
// - enabled channel adjusts from temperature, operating point, limits
// - disabled channel keeps fan start temperature, ordinary auto control
// - lock bit set makes register read-only, writes ignored
// - register at 0x8E, resets to zero
// - operating points at 0x8B, 0x8C, 0x8D, reset to 100 degrees
`timescale 1ns/100ps
`default_nettype none
module dfc_ctrl (
    input  wire logic            clk,            // 25 MHz system clock
    input  wire logic            rst_n,          // async reset, low
    input  wire logic            clk_en,         // freezes state when low
    // internal register port from the serial management interface
    input  wire logic [7:0]      reg_addr,       // register address
    input  wire logic            reg_wr,         // write strobe, one cycle
    input  wire logic [7:0]      reg_wdata,      // write data
    input  wire logic            reg_rd,         // read strobe, one cycle
    output logic      [7:0]      reg_rdata,      // read data, registered
    input  wire logic            lock,           // config lock bit
    // monitoring inputs
    input  wire logic            monitor_tick,   // monitoring cycle pulse
    input  wire logic            overtemp_line,  // overtemp line asserted
    input  wire logic [2:0][7:0] cur_temp,       // latest temps per channel
    input  wire logic [2:0][7:0] hi_limit,       // high limits
    input  wire logic [2:0][7:0] lo_limit,       // low limits
    input  wire logic [2:0][7:0] floor_prog,     // programmed start temps
    input  wire logic [2:0]      ivl_r1,         // remote 1 interval code
    input  wire logic [2:0]      ivl_loc,        // local interval code
    input  wire logic [1:0]      ivl_r2_low,     // remote 2 interval low bits
    // core supply
    input  wire logic            standby_power,  // running on standby rail
    input  wire logic [7:0]      core_supply_reading, // core voltage reading
    input  wire logic [7:0]      core_low_limit, // core low limit
    input  wire logic            core_alert_en,  // alert enabled for core low
    // outputs
    output logic                 core_low_status, // status reg 1 bit 1
    output logic                 alert_out,      // alert request
    output logic                 processor_hot_monitor_en, // hot monitor on
    output logic                 shutdown_block, // shutdown forbidden
    output logic [2:0][7:0]      fan_start_temperature // floors in use
);
    logic [7:0]      ctrl_ff;
    logic [7:0]      nxt_ctrl;
    logic [7:0]      rdata_ff;
    logic [7:0]      nxt_rdata;
    logic            undervolt_ff;
    logic            nxt_undervolt;
    logic            capture_evt;
    logic [2:0]      op_wr;
    logic [2:0][7:0] op_point;
    logic [2:0]      adj_en;
    logic [2:0][2:0] ivl_code;
    logic            wr_ok;

    // writes only pass while unlocked
    assign wr_ok = reg_wr && !lock;

    // control register next value
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_ok && reg_addr == dfc_pkg::ADDR_CTRL1) begin
            nxt_ctrl = reg_wdata;
        end
    end

    // control register state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= dfc_pkg::CTRL1_RESET;
        end else if (clk_en) begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // core undervolt condition follows the reading both ways
    always_comb begin
        nxt_undervolt = ctrl_ff[dfc_pkg::BIT_CORE_POLICY] && standby_power
                        && (core_supply_reading < core_low_limit);
    end

    // undervolt state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            undervolt_ff <= 1'b0;
        end else if (clk_en) begin
            undervolt_ff <= nxt_undervolt;
        end
    end

    // policy outputs
    assign core_low_status          = undervolt_ff;
    assign processor_hot_monitor_en = !undervolt_ff;
    assign shutdown_block           = undervolt_ff;
    assign alert_out                = undervolt_ff && core_alert_en;

    // capture happens on the tick that sees the line asserted
    assign capture_evt = monitor_tick && overtemp_line;

    // remote 2 interval spans both registers
    assign ivl_code[dfc_pkg::CH_R1]  = ivl_r1;
    assign ivl_code[dfc_pkg::CH_LOC] = ivl_loc;
    assign ivl_code[dfc_pkg::CH_R2]  =
        {ctrl_ff[dfc_pkg::BIT_R2_IVL_MSB], ivl_r2_low};

    // per channel operating point and floor adjuster
    genvar g;
    generate
        for (g = 0; g < dfc_pkg::NCH; g = g + 1) begin : g_ch
            // channel address decode
            assign op_wr[g] = wr_ok
                && (reg_addr == dfc_pkg::ADDR_OP_R1 + 8'(g));
            // dynamic adjust off during core undervolt, floor returns to programmed value
            assign adj_en[g] = ctrl_ff[dfc_pkg::BIT_ENABLE0 + g]
                && !undervolt_ff;

            dfc_oppoint u_op (
                .clk         (clk),
                .rst_n       (rst_n),
                .clk_en      (clk_en),
                .wr_en       (op_wr[g]),
                .wr_data     (reg_wdata),
                .capture_en  (ctrl_ff[dfc_pkg::BIT_CAPTURE0 + g]),
                .capture_evt (capture_evt),
                .cur_temp    (cur_temp[g]),
                .op_point    (op_point[g])
            );

            dfc_adjust u_adj (
                .clk        (clk),
                .rst_n      (rst_n),
                .clk_en     (clk_en),
                .enable     (adj_en[g]),
                .tick       (monitor_tick),
                .ivl_code   (ivl_code[g]),
                .cur_temp   (cur_temp[g]),
                .op_point   (op_point[g]),
                .hi_limit   (hi_limit[g]),
                .lo_limit   (lo_limit[g]),
                .floor_prog (floor_prog[g]),
                .floor_out  (fan_start_temperature[g])
            );

            // per channel checks
            a_ch_capture: assert property (
                @(posedge clk) disable iff (!rst_n)
                (clk_en && ctrl_ff[dfc_pkg::BIT_CAPTURE0 + g] && capture_evt)
                |=> (op_point[g] == $past(cur_temp[g])))
                else $error("channel capture missed");
            a_ch_hold: assert property (
                @(posedge clk) disable iff (!rst_n)
                (clk_en && !ctrl_ff[dfc_pkg::BIT_CAPTURE0 + g] && !op_wr[g])
                |=> (op_point[g] == $past(op_point[g])))
                else $error("operating point moved without write or capture");
            a_ch_write: assert property (
                @(posedge clk) disable iff (!rst_n)
                (clk_en && op_wr[g] && !capture_evt)
                |=> (op_point[g] == $past(reg_wdata)))
                else $error("operating point write not stored");
            a_ch_disabled: assert property (
                @(posedge clk) disable iff (!rst_n)
                (clk_en && !ctrl_ff[dfc_pkg::BIT_ENABLE0 + g])
                |=> (fan_start_temperature[g] == $past(floor_prog[g])))
                else $error("disabled channel floor not programmed value");
            a_ch_freeze: assert property (
                @(posedge clk) disable iff (!rst_n)
                (!clk_en) |=> (op_point[g] == $past(op_point[g])
                    && fan_start_temperature[g]
                       == $past(fan_start_temperature[g])))
                else $error("channel state moved while clock enable low");
        end
    endgenerate

    // read mux, unmapped reads return zero
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            case (reg_addr)
                dfc_pkg::ADDR_CTRL1:  nxt_rdata = ctrl_ff;
                dfc_pkg::ADDR_OP_R1:  nxt_rdata = op_point[dfc_pkg::CH_R1];
                dfc_pkg::ADDR_OP_LOC: nxt_rdata = op_point[dfc_pkg::CH_LOC];
                dfc_pkg::ADDR_OP_R2:  nxt_rdata = op_point[dfc_pkg::CH_R2];
                default:              nxt_rdata = 8'h00;
            endcase
        end
    end

    // read data register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else if (clk_en) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // register bank checks
    a_lock_blocks: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && lock) |=> (ctrl_ff == $past(ctrl_ff)))
        else $error("control register changed while locked");

    a_ctrl_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && reg_wr && !lock && reg_addr == dfc_pkg::ADDR_CTRL1)
        |=> (ctrl_ff == $past(reg_wdata)))
        else $error("unlocked write not stored");

    a_read_ctrl: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && reg_rd && reg_addr == dfc_pkg::ADDR_CTRL1)
        |=> (reg_rdata == $past(ctrl_ff)))
        else $error("control register read back wrong");

    a_read_op: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && reg_rd && reg_addr == dfc_pkg::ADDR_OP_LOC)
        |=> (reg_rdata == $past(op_point[dfc_pkg::CH_LOC])))
        else $error("local operating point read back wrong");

    a_read_unmapped: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && reg_rd && (reg_addr < dfc_pkg::ADDR_OP_R1
                              || reg_addr > dfc_pkg::ADDR_CTRL1))
        |=> (reg_rdata == 8'h00))
        else $error("unmapped read not zero");

    a_read_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!reg_rd) |=> (reg_rdata == $past(reg_rdata)))
        else $error("read data changed without a read");

    a_freeze_state: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!clk_en) |=> (ctrl_ff == $past(ctrl_ff)
                       && undervolt_ff == $past(undervolt_ff)))
        else $error("state moved while clock enable low");

    // core undervolt policy checks
    a_undervolt_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && ctrl_ff[dfc_pkg::BIT_CORE_POLICY] && standby_power
         && core_supply_reading < core_low_limit)
        |=> (core_low_status && shutdown_block && !processor_hot_monitor_en))
        else $error("core undervolt policy not applied");

    a_undervolt_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && core_supply_reading >= core_low_limit)
        |=> (!core_low_status && processor_hot_monitor_en))
        else $error("core undervolt policy did not release");

    a_policy_off: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && (!ctrl_ff[dfc_pkg::BIT_CORE_POLICY] || !standby_power))
        |=> (!core_low_status && !shutdown_block))
        else $error("undervolt policy active without bit or standby");

    a_policy_follow: assert property (
        @(posedge clk) disable iff (!rst_n)
        (processor_hot_monitor_en == !core_low_status)
        && (shutdown_block == core_low_status))
        else $error("policy outputs disagree with status");

    a_alert_gate: assert property (
        @(posedge clk) disable iff (!rst_n)
        alert_out == (core_low_status && core_alert_en))
        else $error("alert not gated by its enable");

    a_adjust_off_uv: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && undervolt_ff)
        |=> (fan_start_temperature == $past(floor_prog)))
        else $error("dynamic adjust not suspended on undervolt");

    // capture and interval checks
    a_r2_capture: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && ctrl_ff[dfc_pkg::BIT_CAPTURE0 + dfc_pkg::CH_R2]
         && monitor_tick && overtemp_line)
        |=> (op_point[dfc_pkg::CH_R2] == $past(cur_temp[dfc_pkg::CH_R2])))
        else $error("remote 2 capture missed");

    a_r2_interval: assert property (
        @(posedge clk) disable iff (!rst_n)
        ivl_code[dfc_pkg::CH_R2][2] == ctrl_ff[dfc_pkg::BIT_R2_IVL_MSB])
        else $error("remote 2 interval top bit wrong");
endmodule
`default_nettype wire

//--- dfc_ctrl_test.sv
// self-checking testbench for the dynamic fan floor control register
`timescale 1ns/100ps
`default_nettype none
module dfc_ctrl_test;
    localparam int   LIMIT = 20000;          // cycle ceiling for a hung run
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            clk_en = 1'b1;
    logic [7:0]      reg_addr = 8'h00;
    logic            reg_wr = 1'b0;
    logic [7:0]      reg_wdata = 8'h00;
    logic            reg_rd = 1'b0;
    logic [7:0]      reg_rdata;
    logic            lock = 1'b0;
    logic            monitor_tick = 1'b0;
    logic            overtemp_line = 1'b0;
    logic [2:0][7:0] cur_temp = '0;
    logic [2:0][7:0] hi_limit = {3{8'hFF}};
    logic [2:0][7:0] lo_limit = {3{8'h20}};
    logic [2:0][7:0] floor_prog = {3{8'h50}};
    logic [2:0]      ivl_r1 = 3'h0;
    logic [2:0]      ivl_loc = 3'h0;
    logic [1:0]      ivl_r2_low = 2'h0;
    logic            standby_power = 1'b0;
    logic [7:0]      core_supply_reading = 8'h00;
    logic [7:0]      core_low_limit = 8'h80;
    logic            core_alert_en = 1'b0;
    logic            core_low_status;
    logic            alert_out;
    logic            hot_en;
    logic            shut_blk;
    logic [2:0][7:0] floors;
    int              errors = 0;
    int              n_compared = 0;
    int              cyc = 0;
    logic [7:0]      lfsr = 8'h5D;

    dfc_ctrl dut (
        .clk                      (clk),
        .rst_n                    (rst_n),
        .clk_en                   (clk_en),
        .reg_addr                 (reg_addr),
        .reg_wr                   (reg_wr),
        .reg_wdata                (reg_wdata),
        .reg_rd                   (reg_rd),
        .reg_rdata                (reg_rdata),
        .lock                     (lock),
        .monitor_tick             (monitor_tick),
        .overtemp_line            (overtemp_line),
        .cur_temp                 (cur_temp),
        .hi_limit                 (hi_limit),
        .lo_limit                 (lo_limit),
        .floor_prog               (floor_prog),
        .ivl_r1                   (ivl_r1),
        .ivl_loc                  (ivl_loc),
        .ivl_r2_low               (ivl_r2_low),
        .standby_power            (standby_power),
        .core_supply_reading      (core_supply_reading),
        .core_low_limit           (core_low_limit),
        .core_alert_en            (core_alert_en),
        .core_low_status          (core_low_status),
        .alert_out                (alert_out),
        .processor_hot_monitor_en (hot_en),
        .shutdown_block           (shut_blk),
        .fan_start_temperature    (floors)
    );

    // clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == LIMIT) begin
            errors = errors + 1;
            end_sim();
        end
    end

    // verdict and end of run
    task automatic end_sim();
        if (errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one comparison, reported on mismatch
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // pseudo-random byte stream, fixed start
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction

    // adjustment steps taken in n ticks at interval code c
    function automatic logic [7:0] n_steps(input int c, input int n);
        return 8'(n >> c);
    endfunction

    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    // one-cycle register read, data taken once settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    // monitoring cycle pulses
    task automatic tick(input int n);
        repeat (n) begin
            @(negedge clk);
            monitor_tick = 1'b1;
            @(negedge clk);
            monitor_tick = 1'b0;
        end
    endtask

    // main sequence
    initial begin
        logic [7:0]      d, c, v, e;
        logic [2:0][7:0] p, t;
        logic            st;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        rd(dfc_pkg::ADDR_CTRL1, v);
        chk(v, dfc_pkg::CTRL1_RESET);
        for (int i = 0; i < 3; i++) begin
            rd(dfc_pkg::ADDR_OP_R1 + 8'(i), v);
            chk(v, dfc_pkg::OP_RESET);
        end
        // random control values read back; the next address is not here
        repeat (8) begin
            d = rnd();
            wr(dfc_pkg::ADDR_CTRL1, d);
            wr(8'h8F, ~d);
            rd(dfc_pkg::ADDR_CTRL1, v);
            chk(v, d);
            rd(8'h8F, v);
            chk(v, 8'h00);
        end
        // locked bank ignores writes
        lock = 1'b1;
        wr(dfc_pkg::ADDR_CTRL1, ~d);
        wr(dfc_pkg::ADDR_OP_R1, 8'h11);
        rd(dfc_pkg::ADDR_CTRL1, v);
        chk(v, d);
        rd(dfc_pkg::ADDR_OP_R1, v);
        chk(v, dfc_pkg::OP_RESET);
        lock = 1'b0;
        // capture on ticks with and without the overtemp line
        for (int k = 0; k < 6; k++) begin
            c = rnd() & 8'h1C;
            wr(dfc_pkg::ADDR_CTRL1, c);
            for (int i = 0; i < 3; i++) begin
                p[i] = rnd();
                t[i] = rnd();
                wr(dfc_pkg::ADDR_OP_R1 + 8'(i), p[i]);
            end
            cur_temp = t;
            overtemp_line = k[0];
            tick(1);
            overtemp_line = 1'b0;
            for (int i = 0; i < 3; i++) begin
                rd(dfc_pkg::ADDR_OP_R1 + 8'(i), v);
                e = (k[0] && c[2 + i]) ? t[i] : p[i];
                chk(v, e);
            end
        end
        // undervolt policy over policy bit, standby rail and reading
        cur_temp = {3{8'h70}};
        for (int k = 0; k < 8; k++) begin
            wr(dfc_pkg::ADDR_CTRL1, k[0] ? 8'h22 : 8'h20);
            v = rnd();
            standby_power = k[1];
            core_alert_en = v[0];
            core_supply_reading = k[2] ? 8'h7F : 8'h80;
            st = k[0] && k[1] && k[2];
            tick(2);
            chk({7'h0, core_low_status}, {7'h0, st});
            chk({7'h0, hot_en}, {7'h0, !st});
            chk({7'h0, shut_blk}, {7'h0, st});
            chk({7'h0, alert_out}, {7'h0, st && v[0]});
            if (st)
                chk(floors[0], floor_prog[0]);
        end
        // dynamic floor stepping, code zero steps on every tick
        standby_power = 1'b0;
        for (int i = 0; i < 3; i++)
            wr(dfc_pkg::ADDR_OP_R1 + 8'(i), 8'h64);
        wr(dfc_pkg::ADDR_CTRL1, 8'h00);
        tick(1);
        for (int i = 0; i < 3; i++)
            chk(floors[i], 8'h50);
        wr(dfc_pkg::ADDR_CTRL1, 8'hE0);
        tick(4);
        for (int i = 0; i < 3; i++)
            chk(floors[i], 8'h4C);
        cur_temp = {3{8'h10}};
        tick(3);
        for (int i = 0; i < 3; i++)
            chk(floors[i], 8'h4F);
        // remote 2 alone, code four via top bit: one step per 16 ticks
        cur_temp = {3{8'h70}};
        wr(dfc_pkg::ADDR_CTRL1, 8'h81);
        tick(32);
        chk(floors[2], 8'h4D);
        chk(floors[0], 8'h50);
        chk(floors[1], 8'h50);
        // remote 1 and local at longer codes, stepping down on the high limit
        hi_limit = {3{8'h30}};
        cur_temp = {3{8'h40}};
        ivl_r1 = 3'h1;
        ivl_loc = 3'h2;
        wr(dfc_pkg::ADDR_CTRL1, 8'h60);
        tick(8);
        chk(floors[0], 8'h50 - n_steps(1, 8));
        chk(floors[1], 8'h50 - n_steps(2, 8));
        chk(floors[2], 8'h50);
        // clock enable low freezes register and floors
        clk_en = 1'b0;
        wr(dfc_pkg::ADDR_CTRL1, 8'h00);
        tick(4);
        clk_en = 1'b1;
        rd(dfc_pkg::ADDR_CTRL1, v);
        chk(v, 8'h60);
        chk(floors[0], 8'h50 - n_steps(1, 8));
        end_sim();
    end
endmodule
`default_nettype wire

//--- dfc_oppoint.sv
// one operating-point register with overtemperature capture
`timescale 1ns/100ps
`default_nettype none
module dfc_oppoint (
    input  wire logic       clk,          // system clock
    input  wire logic       rst_n,        // async reset, low
    input  wire logic       clk_en,       // freezes state when low
    input  wire logic       wr_en,        // unlocked write to this register
    input  wire logic [7:0] wr_data,      // write value
    input  wire logic       capture_en,   // capture bit for this channel
    input  wire logic       capture_evt,  // tick with line asserted
    input  wire logic [7:0] cur_temp,     // latest completed conversion
    output logic      [7:0] op_point      // operating point value
);
    logic [7:0] op_ff;
    logic [7:0] nxt_op;

    // capture beats a software write in the same cycle
    always_comb begin
        nxt_op = op_ff;
        if (wr_en) begin
            nxt_op = wr_data;
        end
        if (capture_en && capture_evt) begin
            nxt_op = cur_temp;
        end
    end

    // register update
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_ff <= dfc_pkg::OP_RESET;
        end else if (clk_en) begin
            op_ff <= nxt_op;
        end
    end

    assign op_point = op_ff;

    a_capture_ignored: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !capture_en && !wr_en) |=> (op_ff == $past(op_ff)))
        else $error("operating point moved with capture off");
    a_capture_takes: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && capture_en && capture_evt) |=> (op_ff == $past(cur_temp)))
        else $error("capture did not load current temperature");
endmodule
`default_nettype wire

//--- dfc_pkg.sv
// constants for the dynamic fan floor control register and its helpers
`default_nettype none
package dfc_pkg;
    localparam int          DW              = 8;
    localparam int          NCH             = 3;
    // register addresses
    localparam logic [7:0]  ADDR_OP_R1      = 8'h8B;
    localparam logic [7:0]  ADDR_OP_LOC     = 8'h8C;
    localparam logic [7:0]  ADDR_OP_R2      = 8'h8D;
    localparam logic [7:0]  ADDR_CTRL1      = 8'h8E;
    // reset values
    localparam logic [7:0]  CTRL1_RESET     = 8'h00;
    localparam logic [7:0]  OP_RESET        = 8'h64;
    // control register field positions
    localparam int          BIT_R2_IVL_MSB  = 0;
    localparam int          BIT_CORE_POLICY = 1;
    localparam int          BIT_CAPTURE0    = 2;
    localparam int          BIT_ENABLE0     = 5;
    // channel indices
    localparam int          CH_R1           = 0;
    localparam int          CH_LOC          = 1;
    localparam int          CH_R2           = 2;
    // adjustment step and interval shaping
    localparam logic [7:0]  FLOOR_STEP      = 8'h01;
    localparam logic [7:0]  IVL_BASE        = 8'h01;
    localparam logic [7:0]  TEMP_MIN        = 8'h00;
    localparam logic [7:0]  TEMP_MAX        = 8'hFF;
endpackage
`default_nettype wire
